// File: vscc_pkg.sv
// vscc_pkg: register offsets, field positions, reset values for sync/clamp control
// assumes: 8-bit register port with 8-bit addresses, one pixel clock domain
package vscc_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // register offsets
  localparam logic [7:0] ADDR_CLAMP_START  = 8'h05;
  localparam logic [7:0] ADDR_CLAMP_LEN    = 8'h06;
  localparam logic [7:0] ADDR_SYNC_OUT_LEN = 8'h07;
  localparam logic [7:0] ADDR_GAIN_A       = 8'h08;
  localparam logic [7:0] ADDR_GAIN_B       = 8'h09;
  localparam logic [7:0] ADDR_GAIN_C       = 8'h0a;
  localparam logic [7:0] ADDR_OFFSET_A     = 8'h0b;
  localparam logic [7:0] ADDR_OFFSET_B     = 8'h0c;
  localparam logic [7:0] ADDR_OFFSET_C     = 8'h0d;
  localparam logic [7:0] ADDR_ROUTING      = 8'h0e;
  localparam logic [7:0] ADDR_CLAMP_CTRL   = 8'h0f;
  localparam logic [7:0] ADDR_AUTO_OFFSET  = 8'h1d;

  // sync routing control fields
  localparam int unsigned RT_HPOL_OVR  = 7;
  localparam int unsigned RT_HPOL      = 6;
  localparam int unsigned RT_HOUT_POL  = 5;
  localparam int unsigned RT_HSRC_OVR  = 4;
  localparam int unsigned RT_HSRC_SEL  = 3;
  localparam int unsigned RT_VOUT_INV  = 2;
  localparam int unsigned RT_VSRC_OVR  = 1;
  localparam int unsigned RT_VSRC_SEL  = 0;

  // clamp control fields
  localparam int unsigned CC_CLAMP_EXT = 7;
  localparam int unsigned CC_CLAMP_POL = 6;

  // auto offset control field
  localparam int unsigned AO_ENABLE    = 7;

  // offset field position
  localparam int unsigned OFS_MSB = 7;
  localparam int unsigned OFS_LSB = 1;
  localparam int unsigned OFS_W   = OFS_MSB - OFS_LSB + 1;

  // reset values
  localparam logic [7:0] RST_CLAMP_START  = 8'h01;
  localparam logic [7:0] RST_CLAMP_LEN    = 8'h00;
  localparam logic [7:0] RST_SYNC_OUT_LEN = 8'h00;
  localparam logic [7:0] RST_GAIN         = 8'h00;
  localparam logic [7:0] RST_OFFSET       = 8'h00;
  localparam logic [7:0] RST_ROUTING      = 8'h40;
  localparam logic [7:0] RST_CLAMP_CTRL   = 8'h40;
  localparam logic [7:0] RST_AUTO_OFFSET  = 8'h00;

  localparam logic [7:0] ONE_8  = 8'h01;
  localparam logic [7:0] ZERO_8 = 8'h00;

endpackage

// File: vscc_top.sv
// vscc_top: clamp window, sync output pulse, sync routing and digital offset adder
// assumes: runs on the pixel clock; sync and clamp pins are asynchronous and are
// synchronised here; register port is a simple same-clock write/read strobe port
`timescale 1ns/1ps
`default_nettype none

module vscc_top
#(
  parameter int unsigned CHAN_W = 8
)
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_reset_n,
  // register port
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic [7:0]        i_reg_wdata,
  output logic      [7:0]        o_reg_rdata,
  // asynchronous sync and clamp pins
  input  wire logic              i_line_sync,
  input  wire logic              i_green_embedded_sync,
  input  wire logic              i_frame_sync,
  input  wire logic              i_frame_sync_sep,
  input  wire logic              i_ext_clamp,
  // detector status from the front end
  input  wire logic              i_line_sync_present,
  input  wire logic              i_green_sync_present,
  input  wire logic              i_frame_sync_present,
  input  wire logic              i_detected_polarity,
  input  wire logic              i_feedback_tick,
  // conversion stream in
  input  wire logic              i_conv_valid,
  output logic                   o_conv_ready,
  input  wire logic [CHAN_W-1:0] i_conv_a,
  input  wire logic [CHAN_W-1:0] i_conv_b,
  input  wire logic [CHAN_W-1:0] i_conv_c,
  // conversion stream out
  output logic                   o_pix_valid,
  input  wire logic              i_pix_ready,
  output logic      [CHAN_W-1:0] o_pix_a,
  output logic      [CHAN_W-1:0] o_pix_b,
  output logic      [CHAN_W-1:0] o_pix_c,
  // front-end controls and sync outputs
  output logic                   o_clamp,
  output logic                   o_sync_out,
  output logic                   o_green_sync_out,
  output logic                   o_frame_sync_out,
  output logic                   o_sync_src_green,
  output logic      [7:0]        o_gain_a,
  output logic      [7:0]        o_gain_b,
  output logic      [7:0]        o_gain_c,
  output logic      [6:0]        o_manual_offset_a,
  output logic      [6:0]        o_manual_offset_b,
  output logic      [6:0]        o_manual_offset_c,
  output logic                   o_auto_offset_on
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] clamp_start_delay_q;
  logic [7:0] clamp_window_length_q;
  logic [7:0] sync_out_pulse_length_q;
  logic [7:0] gain_q   [3];
  logic [7:0] offset_q [3];
  logic [7:0] sync_routing_control_q;
  logic [7:0] clamp_and_coast_control_q;
  logic [7:0] auto_offset_control_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      clamp_start_delay_q       <= vscc_pkg::RST_CLAMP_START;
      clamp_window_length_q     <= vscc_pkg::RST_CLAMP_LEN;
      sync_out_pulse_length_q   <= vscc_pkg::RST_SYNC_OUT_LEN;
      for (int i = 0; i < 3; i++)
      begin
        gain_q[i]   <= vscc_pkg::RST_GAIN;
        offset_q[i] <= vscc_pkg::RST_OFFSET;
      end
      sync_routing_control_q    <= vscc_pkg::RST_ROUTING;
      clamp_and_coast_control_q <= vscc_pkg::RST_CLAMP_CTRL;
      auto_offset_control_q     <= vscc_pkg::RST_AUTO_OFFSET;
    end
    else if (i_reg_wr)
    begin
      case (i_reg_addr)
        vscc_pkg::ADDR_CLAMP_START:  clamp_start_delay_q       <= i_reg_wdata;
        vscc_pkg::ADDR_CLAMP_LEN:    clamp_window_length_q     <= i_reg_wdata;
        vscc_pkg::ADDR_SYNC_OUT_LEN: sync_out_pulse_length_q   <= i_reg_wdata;
        vscc_pkg::ADDR_GAIN_A:       gain_q[0]                 <= i_reg_wdata;
        vscc_pkg::ADDR_GAIN_B:       gain_q[1]                 <= i_reg_wdata;
        vscc_pkg::ADDR_GAIN_C:       gain_q[2]                 <= i_reg_wdata;
        vscc_pkg::ADDR_OFFSET_A:     offset_q[0]               <= i_reg_wdata;
        vscc_pkg::ADDR_OFFSET_B:     offset_q[1]               <= i_reg_wdata;
        vscc_pkg::ADDR_OFFSET_C:     offset_q[2]               <= i_reg_wdata;
        vscc_pkg::ADDR_ROUTING:      sync_routing_control_q    <= i_reg_wdata;
        vscc_pkg::ADDR_CLAMP_CTRL:   clamp_and_coast_control_q <= i_reg_wdata;
        vscc_pkg::ADDR_AUTO_OFFSET:  auto_offset_control_q     <= i_reg_wdata;
        default:                     ;
      endcase
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_reg_rdata <= vscc_pkg::ZERO_8;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        vscc_pkg::ADDR_CLAMP_START:  o_reg_rdata <= clamp_start_delay_q;
        vscc_pkg::ADDR_CLAMP_LEN:    o_reg_rdata <= clamp_window_length_q;
        vscc_pkg::ADDR_SYNC_OUT_LEN: o_reg_rdata <= sync_out_pulse_length_q;
        vscc_pkg::ADDR_GAIN_A:       o_reg_rdata <= gain_q[0];
        vscc_pkg::ADDR_GAIN_B:       o_reg_rdata <= gain_q[1];
        vscc_pkg::ADDR_GAIN_C:       o_reg_rdata <= gain_q[2];
        vscc_pkg::ADDR_OFFSET_A:     o_reg_rdata <= {offset_q[0][7:1], 1'b0};
        vscc_pkg::ADDR_OFFSET_B:     o_reg_rdata <= {offset_q[1][7:1], 1'b0};
        vscc_pkg::ADDR_OFFSET_C:     o_reg_rdata <= {offset_q[2][7:1], 1'b0};
        vscc_pkg::ADDR_ROUTING:      o_reg_rdata <= sync_routing_control_q;
        vscc_pkg::ADDR_CLAMP_CTRL:   o_reg_rdata <= clamp_and_coast_control_q;
        vscc_pkg::ADDR_AUTO_OFFSET:  o_reg_rdata <= auto_offset_control_q;
        default:                     o_reg_rdata <= vscc_pkg::ZERO_8;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  localparam int unsigned NSYNC = 5;
  logic [NSYNC-1:0] pin_meta_q;
  logic [NSYNC-1:0] pin_sync_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= {i_ext_clamp, i_frame_sync_sep, i_frame_sync,
                     i_green_embedded_sync, i_line_sync};
      pin_sync_q <= pin_meta_q;
    end
  end

  wire logic line_pin   = pin_sync_q[0];
  wire logic green_pin  = pin_sync_q[1];
  wire logic frame_pin  = pin_sync_q[2];
  wire logic frame_sep  = pin_sync_q[3];
  wire logic clamp_pin  = pin_sync_q[4];

  ////////////////////////////////////////////////////////////////////////////
  // sync source and polarity
  logic use_green;
  logic ref_pol;
  logic use_sep;

  always_comb
  begin
    if (sync_routing_control_q[vscc_pkg::RT_HSRC_OVR])
      use_green = sync_routing_control_q[vscc_pkg::RT_HSRC_SEL];
    else if (i_line_sync_present == i_green_sync_present)
      use_green = sync_routing_control_q[vscc_pkg::RT_HSRC_SEL];
    else
      use_green = i_green_sync_present;
    ref_pol = sync_routing_control_q[vscc_pkg::RT_HPOL_OVR] ?
              sync_routing_control_q[vscc_pkg::RT_HPOL] : i_detected_polarity;
    use_sep = sync_routing_control_q[vscc_pkg::RT_VSRC_OVR] ?
              sync_routing_control_q[vscc_pkg::RT_VSRC_SEL] : !i_frame_sync_present;
  end

  wire logic line_src = use_green ? green_pin : line_pin;
  logic line_src_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      line_src_q <= 1'b0;
    else
      line_src_q <= line_src;
  end

  // reference edge: rising when polarity 1, falling when 0; other edge ignored
  wire logic ref_edge = ref_pol ? (line_src & ~line_src_q)
                                : (~line_src & line_src_q);

  ////////////////////////////////////////////////////////////////////////////
  // internal clamp window; settings latched per line so writes land next line
  logic [7:0] clamp_cnt_q;
  logic [7:0] clamp_start_line_q;
  logic [7:0] clamp_len_line_q;
  logic       clamp_int_q;
  logic       clamp_armed_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      clamp_cnt_q        <= vscc_pkg::ZERO_8;
      clamp_start_line_q <= vscc_pkg::RST_CLAMP_START;
      clamp_len_line_q   <= vscc_pkg::RST_CLAMP_LEN;
      clamp_int_q        <= 1'b0;
      clamp_armed_q      <= 1'b0;
    end
    else if (ref_edge)
    begin
      clamp_cnt_q        <= vscc_pkg::ONE_8;
      clamp_start_line_q <= clamp_start_delay_q;
      clamp_len_line_q   <= clamp_window_length_q;
      clamp_int_q        <= 1'b0;
      clamp_armed_q      <= (clamp_window_length_q != vscc_pkg::ZERO_8);
    end
    else if (clamp_armed_q && !clamp_int_q)
    begin
      clamp_cnt_q <= clamp_cnt_q + vscc_pkg::ONE_8;
      if (clamp_cnt_q >= clamp_start_line_q)
      begin
        clamp_int_q <= 1'b1;
        clamp_cnt_q <= vscc_pkg::ONE_8;
      end
    end
    else if (clamp_int_q)
    begin
      clamp_cnt_q <= clamp_cnt_q + vscc_pkg::ONE_8;
      if (clamp_cnt_q >= clamp_len_line_q)
      begin
        clamp_int_q   <= 1'b0;
        clamp_armed_q <= 1'b0;
      end
    end
  end

  // external pin bypasses the counters entirely
  wire logic clamp_ext_on = clamp_and_coast_control_q[vscc_pkg::CC_CLAMP_POL] ?
                            ~clamp_pin : clamp_pin;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_clamp <= 1'b0;
    else
      o_clamp <= clamp_and_coast_control_q[vscc_pkg::CC_CLAMP_EXT] ?
                 clamp_ext_on : clamp_int_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync output pulse
  logic [7:0] pulse_cnt_q;
  logic       pulse_q;

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pulse_cnt_q <= vscc_pkg::ZERO_8;
      pulse_q     <= 1'b0;
    end
    else if (i_feedback_tick)
    begin
      pulse_cnt_q <= sync_out_pulse_length_q;
      pulse_q     <= (sync_out_pulse_length_q != vscc_pkg::ZERO_8);
    end
    else if (pulse_q)
    begin
      pulse_cnt_q <= pulse_cnt_q - vscc_pkg::ONE_8;
      if (pulse_cnt_q == vscc_pkg::ONE_8)
        pulse_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_sync_out       <= 1'b0;
      o_green_sync_out <= 1'b0;
      o_frame_sync_out <= 1'b0;
      o_sync_src_green <= 1'b0;
    end
    else
    begin
      o_sync_out       <= pulse_q ^ sync_routing_control_q[vscc_pkg::RT_HOUT_POL];
      o_green_sync_out <= green_pin ^ sync_routing_control_q[vscc_pkg::RT_HOUT_POL];
      o_frame_sync_out <= (use_sep ? frame_sep : frame_pin) ^
                          ~sync_routing_control_q[vscc_pkg::RT_VOUT_INV];
      o_sync_src_green <= use_green;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain and manual offset codes to the front end
  wire logic auto_on = auto_offset_control_q[vscc_pkg::AO_ENABLE];

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_gain_a          <= vscc_pkg::RST_GAIN;
      o_gain_b          <= vscc_pkg::RST_GAIN;
      o_gain_c          <= vscc_pkg::RST_GAIN;
      o_manual_offset_a <= '0;
      o_manual_offset_b <= '0;
      o_manual_offset_c <= '0;
      o_auto_offset_on  <= 1'b0;
    end
    else
    begin
      o_gain_a          <= gain_q[0];
      o_gain_b          <= gain_q[1];
      o_gain_c          <= gain_q[2];
      o_manual_offset_a <= offset_q[0][vscc_pkg::OFS_MSB:vscc_pkg::OFS_LSB];
      o_manual_offset_b <= offset_q[1][vscc_pkg::OFS_MSB:vscc_pkg::OFS_LSB];
      o_manual_offset_c <= offset_q[2][vscc_pkg::OFS_MSB:vscc_pkg::OFS_LSB];
      o_auto_offset_on  <= auto_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // digital offset adder with two-entry skid buffer
  // sum saturates so a brightness trim never wraps black to white
  function automatic logic [CHAN_W-1:0] add_ofs(input logic [CHAN_W-1:0] v,
                                                input logic [7:0]        r,
                                                input logic              en);
    logic signed [CHAN_W+1:0] s;
    s = $signed({2'b00, v}) + $signed({{(CHAN_W-5){r[7]}}, r[7:1]});
    if (!en)
      add_ofs = v;
    else if (s < 0)
      add_ofs = '0;
    else if (s[CHAN_W])
      add_ofs = '1;
    else
      add_ofs = s[CHAN_W-1:0];
  endfunction

  localparam int unsigned ENT_W = 3 * CHAN_W;
  logic [ENT_W-1:0] buf_q [2];
  logic [1:0]       cnt_q;
  wire logic        push = i_conv_valid && o_conv_ready;
  wire logic        pop  = o_pix_valid && i_pix_ready;
  wire logic [ENT_W-1:0] in_word = {add_ofs(i_conv_a, offset_q[0], auto_on),
                                    add_ofs(i_conv_b, offset_q[1], auto_on),
                                    add_ofs(i_conv_c, offset_q[2], auto_on)};

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      buf_q[0] <= '0;
      buf_q[1] <= '0;
      cnt_q    <= 2'd0;
    end
    else
    begin
      if (pop)
        buf_q[0] <= buf_q[1];
      if (push)
      begin
        if (cnt_q == 2'd0 || (cnt_q == 2'd1 && pop))
          buf_q[0] <= in_word;
        else
          buf_q[1] <= in_word;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_conv_ready <= 1'b0;
      o_pix_valid  <= 1'b0;
    end
    else
    begin
      o_conv_ready <= (cnt_q + {1'b0, push} - {1'b0, pop}) < 2'd2;
      o_pix_valid  <= (cnt_q + {1'b0, push} - {1'b0, pop}) != 2'd0;
    end
  end

  assign o_pix_a = buf_q[0][3*CHAN_W-1:2*CHAN_W];
  assign o_pix_b = buf_q[0][2*CHAN_W-1:CHAN_W];
  assign o_pix_c = buf_q[0][CHAN_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_ext_clamp_follows: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    clamp_and_coast_control_q[vscc_pkg::CC_CLAMP_EXT] && $stable(clamp_and_coast_control_q)
    |=> o_clamp == $past(clamp_ext_on))
    else $error("external clamp not followed");
  a_int_clamp_start: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(clamp_int_q) |-> clamp_armed_q && !ref_edge[*1])
    else $error("clamp window rose without arming");
  a_clamp_ignores_regs: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    clamp_and_coast_control_q[vscc_pkg::CC_CLAMP_EXT] ##1
    clamp_and_coast_control_q[vscc_pkg::CC_CLAMP_EXT] |-> o_clamp == $past(clamp_ext_on))
    else $error("clamp registers affect external mode");
  a_pulse_length: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_feedback_tick && sync_out_pulse_length_q == 8'h05
    ##1 (!i_feedback_tick && pulse_q)[*5] |=> !pulse_q)
    else $error("sync pulse length wrong");
  a_pulse_starts: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    i_feedback_tick && sync_out_pulse_length_q != 8'h00 |=> pulse_q)
    else $error("sync pulse did not start");
  a_out_polarity: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $stable(sync_routing_control_q) |=> o_sync_out ==
    ($past(pulse_q) ^ $past(sync_routing_control_q[vscc_pkg::RT_HOUT_POL])))
    else $error("sync output polarity wrong");
  a_zero_offset: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    offset_q[0][7:1] == 7'h00 |-> in_word[ENT_W-1:2*CHAN_W] == i_conv_a)
    else $error("zero offset changed data");
  a_manual_pass: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !auto_on |-> in_word[CHAN_W-1:0] == i_conv_c)
    else $error("adder active in manual mode");
  a_buffer_full: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    cnt_q == 2'd2 |-> !o_conv_ready)
    else $error("ready while buffer full");

  c_int_clamp:  cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(clamp_int_q));
  c_ext_clamp:  cover property (@(posedge i_clk) disable iff (!i_reset_n)
    clamp_and_coast_control_q[vscc_pkg::CC_CLAMP_EXT] && o_clamp);
  c_pulse:      cover property (@(posedge i_clk) disable iff (!i_reset_n) $fell(pulse_q));
  c_stall_full: cover property (@(posedge i_clk) disable iff (!i_reset_n) cnt_q == 2'd2);

endmodule

`default_nettype wire

// File: vscc_source_model.sv
// vscc_source_model: video source stand-in, line sync pulses and feedback ticks
// assumes: one pixel clock; positive sync pulses, fixed line length in clocks
`timescale 1ns/1ps
`default_nettype none

module vscc_source_model
#(
  parameter int unsigned LINE_LEN = 40,
  parameter int unsigned SYNC_LEN = 4
)
(
  // clock
  input  wire logic i_clk,
  // source outputs
  output logic      o_line_sync,
  output logic      o_tick
);
  int unsigned cnt = 0;

  initial
  begin
    o_line_sync = 1'h0;
    o_tick = 1'h0;
  end

  // driven by nonblocking update so the bench sees it settled after the edge
  always @(posedge i_clk)
  begin
    cnt <= (cnt == LINE_LEN - 1) ? 0 : cnt + 1;
    o_line_sync <= (cnt < SYNC_LEN);
    o_tick <= (cnt == 0);
  end
endmodule
`default_nettype wire

// File: tb_video_sync_clamp_control.sv
// tb_video_sync_clamp_control: self-checking bench for vscc_top
// assumes: vscc_source_model supplies line sync and feedback ticks
`timescale 1ns/1ps
`default_nettype none

module tb_video_sync_clamp_control;
  logic i_clk = 0, i_reset_n = 0, i_reg_wr = 0, i_reg_rd = 0, i_ext_clamp = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  logic i_line_sync, i_green_embedded_sync = 0, i_frame_sync = 0;
  logic i_frame_sync_sep = 0, i_line_sync_present = 1, i_green_sync_present = 0;
  logic i_frame_sync_present = 1, i_detected_polarity = 1, i_feedback_tick;
  logic i_conv_valid = 0, o_conv_ready, o_pix_valid, i_pix_ready = 0;
  logic [7:0] i_conv_a = 8'h00, i_conv_b = 8'h00, i_conv_c = 8'h00;
  logic [7:0] o_pix_a, o_pix_b, o_pix_c, o_gain_a, o_gain_b, o_gain_c;
  logic o_clamp, o_sync_out, o_green_sync_out, o_frame_sync_out, o_sync_src_green;
  logic [6:0] o_manual_offset_a, o_manual_offset_b, o_manual_offset_c;
  logic o_auto_offset_on;
  int fail_count = 0, n_compared = 0;

  always #10 i_clk = ~i_clk;

  vscc_source_model vscc_source_model_inst (.i_clk, .o_line_sync(i_line_sync),
    .o_tick(i_feedback_tick));

  vscc_top vscc_top_inst (.i_clk, .i_reset_n, .i_reg_wr, .i_reg_rd, .i_reg_addr,
    .i_reg_wdata, .o_reg_rdata, .i_line_sync, .i_green_embedded_sync, .i_frame_sync,
    .i_frame_sync_sep, .i_ext_clamp, .i_line_sync_present, .i_green_sync_present,
    .i_frame_sync_present, .i_detected_polarity, .i_feedback_tick, .i_conv_valid,
    .o_conv_ready, .i_conv_a, .i_conv_b, .i_conv_c, .o_pix_valid, .i_pix_ready,
    .o_pix_a, .o_pix_b, .o_pix_c, .o_clamp, .o_sync_out, .o_green_sync_out,
    .o_frame_sync_out, .o_sync_src_green, .o_gain_a, .o_gain_b, .o_gain_c,
    .o_manual_offset_a, .o_manual_offset_b, .o_manual_offset_c, .o_auto_offset_on);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // bounded wait, sampled just after the edge
  task automatic wait_lvl(ref logic s, input logic v);
    for (int k = 0; k < 200 && s !== v; k++)
    begin
      @(posedge i_clk);
      #1;
    end
    if (s !== v)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic run_len(ref logic s, input logic v, output int n);
    n = 0;
    while (s === v && n < 100)
    begin
      @(posedge i_clk);
      #1 n++;
    end
  endtask

  // clamp start and length settings are taken at the line reference edge
  task automatic lines();
    repeat (90) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_reg_wr = 1;
    i_reg_addr = a;
    i_reg_wdata = d;
    @(posedge i_clk);
    #1 i_reg_wr = 0;
    // idle edge: the next write never re-raises the strobe in this step
    @(posedge i_clk);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    i_reg_rd = 1;
    i_reg_addr = a;
    @(posedge i_clk);
    #1 i_reg_rd = 0;
    @(posedge i_clk);
    #1 check(nm, o_reg_rdata, exp);
  endtask

  task automatic push(input logic [7:0] v);
    i_conv_valid = 1;
    i_conv_a = v;
    i_conv_b = v;
    i_conv_c = v;
    wait_lvl(o_conv_ready, 1'h1);
    @(posedge i_clk);
    #1 i_conv_valid = 0;
    @(posedge i_clk);
    #1;
  endtask

  task automatic pop(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    wait_lvl(o_pix_valid, 1'h1);
    check("pix_a", o_pix_a, a);
    check("pix_b", o_pix_b, b);
    check("pix_c", o_pix_c, c);
    i_pix_ready = 1;
    @(posedge i_clk);
    #1 i_pix_ready = 0;
    @(posedge i_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_chk(8'h05, 8'h01, "clamp_start");
    rd_chk(8'h0e, 8'h40, "routing");
    rd_chk(8'h0f, 8'h40, "clamp_ctrl");
    wr(8'h30, 8'hff);
    rd_chk(8'h30, 8'h00, "unmapped");
    wr(8'h08, 8'hff);
    wr(8'h0a, 8'h80);
    wr(8'h09, 8'h5a);
    check("gain_b", o_gain_b, 8'h5a);
    check("gain_a", o_gain_a, 8'hff);
    check("gain_c", o_gain_c, 8'h80);
    wr(8'h0b, 8'hff);
    rd_chk(8'h0b, 8'hfe, "offset_a");
    $display("test regs done");
  endtask

  task automatic t_stream();
    wr(8'h0b, 8'h04);
    wr(8'h0c, 8'hfe);
    wr(8'h0d, 8'h00);
    check("man_ofs_a", {1'h0, o_manual_offset_a}, 8'h02);
    check("man_ofs_b", {1'h0, o_manual_offset_b}, 8'h7f);
    check("man_ofs_c", {1'h0, o_manual_offset_c}, 8'h00);
    lines();
    push(8'h30);
    pop(8'h30, 8'h30, 8'h30);
    wr(8'h1d, 8'h80);
    check("auto_on", {7'h0, o_auto_offset_on}, 8'h01);
    lines();
    push(8'h10);
    push(8'h00);
    // stalled receiver: third word must be held off
    i_conv_valid = 1;
    repeat (2) @(posedge i_clk);
    #1 check("conv_ready", {7'h0, o_conv_ready}, 8'h00);
    i_conv_valid = 0;
    pop(8'h12, 8'h0f, 8'h10);
    pop(8'h02, 8'h00, 8'h00);
    $display("test stream done");
  endtask

  task automatic t_clamp();
    int n;
    wr(8'h05, 8'h03);
    wr(8'h06, 8'h04);
    repeat (2) wait_lvl(o_clamp, 1'h1);
    run_len(o_clamp, 1'h1, n);
    check("clamp_len", n[7:0], 8'h04);
    wr(8'h0f, 8'h80);
    i_ext_clamp = 1;
    wait_lvl(o_clamp, 1'h1);
    run_len(o_clamp, 1'h1, n);
    check("ext_hi", n[7:0], 8'h64);
    wr(8'h0f, 8'hc0);
    wait_lvl(o_clamp, 1'h0);
    run_len(o_clamp, 1'h0, n);
    check("ext_quiet", n[7:0], 8'h64);
    i_ext_clamp = 0;
    wait_lvl(o_clamp, 1'h1);
    run_len(o_clamp, 1'h1, n);
    check("ext_lo", n[7:0], 8'h64);
    $display("test clamp done");
  endtask

  task automatic t_sync_out();
    int n;
    i_frame_sync_sep = 1;
    wr(8'h07, 8'h05);
    repeat (2) wait_lvl(o_sync_out, 1'h1);
    run_len(o_sync_out, 1'h1, n);
    check("pulse_len", n[7:0], 8'h05);
    wr(8'h0e, 8'h60);
    lines();
    wait_lvl(o_sync_out, 1'h0);
    run_len(o_sync_out, 1'h0, n);
    check("neg_pulse", n[7:0], 8'h05);
    check("green_out", {7'h0, o_green_sync_out}, 8'h01);
    check("frame_out", {7'h0, o_frame_sync_out}, 8'h01);
    check("src_auto", {7'h0, o_sync_src_green}, 8'h00);
    wr(8'h0e, 8'h7b);
    check("src_forced", {7'h0, o_sync_src_green}, 8'h01);
    check("frame_sep", {7'h0, o_frame_sync_out}, 8'h00);
    $display("test sync out done");
  endtask

  initial
  begin
    repeat (16) @(posedge i_clk);
    #1 i_reset_n = 1;
    t_regs();
    t_stream();
    t_clamp();
    t_sync_out();
    tally_and_finish();
  end
endmodule
`default_nettype wire
